// >>> bps_protect_seq.sv
// bps_protect_seq.sv: fault detection and protection sequencing
// assumes: analog levels arrive already digitized in mV on this clock;
// enable and the load reset are raw pins and are synchronised here.
`include "bps_cfg.svh"
`timescale 1ns/10ps
module bps_protect_seq #(
  parameter int NPH        = 4,
  parameter int HICCUP_CYC = `BPS_HICCUP_CYC
) (
  input  wire logic             ref_clk_i,
  input  wire logic             resetn_i,
  input  wire logic             enable_i,
  input  wire logic             load_reset_n_i,
  input  wire bps_pkg::bps_mv_t vin_mv_i,
  input  wire bps_pkg::bps_mv_t bias_mv_i,
  input  wire bps_pkg::bps_mv_t vout_mv_i,
  input  wire bps_pkg::bps_mv_t target_mv_i,
  input  wire bps_pkg::bps_mv_t droop_mv_i,
  input  wire bps_pkg::bps_mv_t ready_low_margin_mv_i,
  input  wire bps_pkg::bps_mv_t track_ovp_ofs_mv_i,
  input  wire bps_pkg::bps_mv_t fixed_ovp_mv_i,
  input  wire bps_pkg::bps_mv_t thermal_sense_mv_i,
  input  wire logic             input_lockout_wr_i,
  input  wire logic [1:0]       input_lockout_config_i,
  input  wire logic [7:0]       startup_voltage_i,
  input  wire logic             setpoint_wr_i,
  input  wire logic [7:0]       setpoint_i,
  input  wire logic [2:0]       slew_sel_i,
  input  wire logic [NPH-1:0]   pwm_demand_i,
  output logic      [NPH-1:0]   phase_level_o,
  output logic      [NPH-1:0]   phase_tristate_o,
  output logic                  skip_mode_output_o,
  output logic                  power_good_output_o,
  output logic      [10:0]      stage_temp_output_o,
  output logic                  stage_fault_o,
  output logic      [7:0]       output_setpoint_o,
  output logic      [7:0]       target_voltage_o,
  output logic                  revert_fault_o,
  output logic                  uvp_o,
  output logic                  track_ovp_o,
  output logic                  fixed_ovp_o,
  output logic                  prebias_ovp_o,
  output logic                  converter_on_o,
  output logic      [1:0]       input_lockout_config_o
);

  localparam logic [15:0] RST_CYC = 16'(`BPS_RST_CYC);
  localparam logic [31:0] HIC_CYC = 32'(HICCUP_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and temperature conversion

  logic [1:0] pins_s;
  logic       enable_s;
  logic       load_reset_n_s;

  bps_sync #(.W(2)) u_sync (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .d_i       ({enable_i, load_reset_n_i}),
    .q_o       (pins_s)
  );

  assign enable_s       = pins_s[1];
  assign load_reset_n_s = pins_s[0];

  bps_temp_if tif ();
  assign tif.sense_mv = thermal_sense_mv_i;
  bps_temp_conv u_conv (.t(tif.conv));

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      stage_temp_output_o <= 11'h000;
      stage_fault_o       <= 1'b0;
    end else begin
      stage_temp_output_o <= tif.temp_dc;
      stage_fault_o       <= tif.stage_fault;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // supply lockouts

  function automatic logic [31:0] uvlo_levels(input logic [1:0] cfg);
    case (cfg)
      2'h0:    uvlo_levels = {`BPS_UVLO0_ON_MV, `BPS_UVLO0_OFF_MV};
      2'h1:    uvlo_levels = {`BPS_UVLO1_ON_MV, `BPS_UVLO1_OFF_MV};
      2'h2:    uvlo_levels = {`BPS_UVLO2_ON_MV, `BPS_UVLO2_OFF_MV};
      default: uvlo_levels = {`BPS_UVLO3_ON_MV, `BPS_UVLO3_OFF_MV};
    endcase
  endfunction

  logic [31:0] uvlo_lv;
  logic        vin_ok_r;
  logic        bias_ok_r;
  logic        allowed;

  assign uvlo_lv = uvlo_levels(input_lockout_config_o);
  assign allowed = vin_ok_r && bias_ok_r && enable_s;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      input_lockout_config_o <= `BPS_UVLO_CFG_RST;
    end else if (input_lockout_wr_i) begin
      input_lockout_config_o <= input_lockout_config_i;
    end
  end

  // hysteresis: between the two levels the previous verdict is kept
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      vin_ok_r  <= 1'b0;
      bias_ok_r <= 1'b0;
    end else begin
      if (vin_mv_i < uvlo_lv[15:0]) begin
        vin_ok_r <= 1'b0;
      end else if (vin_mv_i > uvlo_lv[31:16]) begin
        vin_ok_r <= 1'b1;
      end
      if (bias_mv_i < `BPS_BIAS_OFF_MV) begin
        bias_ok_r <= 1'b0;
      end else if (bias_mv_i > `BPS_BIAS_ON_MV) begin
        bias_ok_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // load reset: revert to the boot voltage

  logic [15:0] rst_cnt_r;
  logic        revert_go;

  assign revert_go = !load_reset_n_s && (rst_cnt_r == RST_CYC - 16'h0001);

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      rst_cnt_r      <= 16'h0000;
      revert_fault_o <= 1'b0;
    end else if (load_reset_n_s) begin
      rst_cnt_r      <= 16'h0000;
      revert_fault_o <= 1'b0;
    end else begin
      if (rst_cnt_r != RST_CYC) begin
        rst_cnt_r <= rst_cnt_r + 16'h0001;
      end
      if (revert_go) begin
        revert_fault_o <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing state

  bps_pkg::bps_state_e st_r;
  logic [31:0]         hic_cnt_r;
  logic                uv_cond;
  logic                ss_start;
  logic [15:0]         uv_floor;

  // a negative floor cannot trip; saturate instead of wrapping
  assign uv_floor = ({1'b0, target_mv_i} > {1'b0, droop_mv_i} + {1'b0, ready_low_margin_mv_i}) ?
                    16'(target_mv_i - droop_mv_i - ready_low_margin_mv_i) : 16'h0000;
  assign uv_cond  = (vout_mv_i < uv_floor);
  assign ss_start = allowed && ((st_r == bps_pkg::ST_OFF) ||
                    (st_r == bps_pkg::ST_HICCUP && hic_cnt_r == HIC_CYC - 32'h1));

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      st_r      <= bps_pkg::ST_OFF;
      hic_cnt_r <= 32'h0;
    end else if (!allowed) begin
      st_r      <= bps_pkg::ST_OFF;
      hic_cnt_r <= 32'h0;
    end else begin
      case (st_r)
        bps_pkg::ST_OFF: begin
          st_r <= bps_pkg::ST_SOFT;
        end
        bps_pkg::ST_SOFT: begin
          if (target_voltage_o == output_setpoint_o) begin
            st_r <= bps_pkg::ST_RUN;
          end
        end
        bps_pkg::ST_RUN: begin
          if (uv_cond) begin
            st_r      <= bps_pkg::ST_HICCUP;
            hic_cnt_r <= 32'h0;
          end
        end
        bps_pkg::ST_HICCUP: begin
          if (ss_start) begin
            st_r <= bps_pkg::ST_SOFT;
          end else begin
            hic_cnt_r <= hic_cnt_r + 32'h1;
          end
        end
        default: begin
          st_r <= bps_pkg::ST_OFF;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // setpoint and slewed target

  logic [15:0] slew_cnt_r;
  logic        slew_tick;

  assign slew_tick = (slew_cnt_r == 16'({3'h0, slew_sel_i} + 6'h01) * `BPS_SLEW_BASE_CYC);

  // revert wins over a host write in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      output_setpoint_o <= 8'h00;
    end else if (revert_go || ss_start) begin
      output_setpoint_o <= startup_voltage_i;
    end else if (setpoint_wr_i) begin
      output_setpoint_o <= setpoint_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      slew_cnt_r       <= 16'h0000;
      target_voltage_o <= 8'h00;
    end else if (st_r == bps_pkg::ST_OFF) begin
      slew_cnt_r       <= 16'h0000;
      target_voltage_o <= 8'h00;
    end else if (slew_tick) begin
      slew_cnt_r <= 16'h0000;
      if (target_voltage_o < output_setpoint_o) begin
        target_voltage_o <= target_voltage_o + 8'h01;
      end else if (target_voltage_o > output_setpoint_o) begin
        target_voltage_o <= target_voltage_o - 8'h01;
      end
    end else begin
      slew_cnt_r <= slew_cnt_r + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // overvoltage detection

  logic target_moving;
  logic track_cond;
  logic fixed_cond;
  logic prebias_cond;

  assign target_moving = (target_voltage_o != output_setpoint_o);
  assign track_cond    = (st_r == bps_pkg::ST_RUN || st_r == bps_pkg::ST_SOFT) &&
                         !target_moving &&
                         ({1'b0, vout_mv_i} > {1'b0, target_mv_i} + {1'b0, track_ovp_ofs_mv_i});
  assign fixed_cond    = bias_ok_r && (vout_mv_i > fixed_ovp_mv_i);
  assign prebias_cond  = !enable_s && (vout_mv_i > `BPS_PREBIAS_OVP_MV);

  // fixed and pre-bias latches: a new event wins over the clearing condition; tracking ovp follows its condition
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      track_ovp_o   <= 1'b0;
      fixed_ovp_o   <= 1'b0;
      prebias_ovp_o <= 1'b0;
    end else begin
      track_ovp_o <= track_cond;
      if (fixed_cond) begin
        fixed_ovp_o <= 1'b1;
      end else if (!enable_s || !bias_ok_r) begin
        fixed_ovp_o <= 1'b0;
      end
      if (prebias_cond) begin
        prebias_ovp_o <= 1'b1;
      end else if (!bias_ok_r) begin
        prebias_ovp_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // phase drive, skip, power good

  logic force_low;
  logic all_off;

  assign force_low = track_cond || fixed_cond || prebias_cond ||
                     track_ovp_o || fixed_ovp_o || prebias_ovp_o;
  assign all_off   = (st_r == bps_pkg::ST_OFF) || (st_r == bps_pkg::ST_HICCUP) ||
                     (st_r == bps_pkg::ST_RUN && uv_cond) || tif.stage_fault;

  // low side on beats all-off: it discharges an overvoltage
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      phase_level_o    <= '0;
      phase_tristate_o <= '1;
    end else if (force_low) begin
      phase_level_o    <= '0;
      phase_tristate_o <= '0;
    end else if (all_off) begin
      phase_level_o    <= '0;
      phase_tristate_o <= '1;
    end else begin
      phase_level_o    <= pwm_demand_i;
      phase_tristate_o <= '0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      skip_mode_output_o  <= 1'b1;
      power_good_output_o <= 1'b0;
      uvp_o               <= 1'b0;
      converter_on_o      <= 1'b0;
    end else begin
      skip_mode_output_o  <= !(st_r == bps_pkg::ST_SOFT || ss_start);
      power_good_output_o <= (st_r == bps_pkg::ST_RUN) && !uv_cond && !force_low;
      uvp_o               <= (st_r == bps_pkg::ST_HICCUP);
      converter_on_o      <= allowed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  property p_skip_soft;
    st_r == bps_pkg::ST_SOFT |=> !skip_mode_output_o;
  endproperty
  a_skip_soft: assert property (p_skip_soft) else $error("skip not low in soft start");

  property p_temp_sat;
    thermal_sense_mv_i > 16'h0c00 |=> stage_temp_output_o == `BPS_TEMP_MAX_DC;
  endproperty
  a_temp_sat: assert property (p_temp_sat) else $error("temperature not saturated");

  property p_stage_fault;
    tif.stage_fault && !force_low |=> stage_fault_o && phase_tristate_o == '1;
  endproperty
  a_stage_fault: assert property (p_stage_fault) else $error("stage fault not off");

  property p_revert;
    revert_go |=> revert_fault_o && output_setpoint_o == $past(startup_voltage_i);
  endproperty
  a_revert: assert property (p_revert) else $error("revert not applied");

  property p_revert_delay;
    $rose(revert_fault_o) |-> $past(!load_reset_n_s, 100);
  endproperty
  a_revert_delay: assert property (p_revert_delay) else $error("revert too early");

  property p_revert_clr;
    load_reset_n_s |=> !revert_fault_o;
  endproperty
  a_revert_clr: assert property (p_revert_clr) else $error("revert flag not cleared");

  property p_slew;
    $changed(target_voltage_o) && $past(st_r) != bps_pkg::ST_OFF |-> $past(slew_tick);
  endproperty
  a_slew: assert property (p_slew) else $error("target moved off slew tick");

  property p_lockout;
    !allowed |=> st_r == bps_pkg::ST_OFF ##1 phase_tristate_o == '1 || force_low;
  endproperty
  a_lockout: assert property (p_lockout) else $error("lockout did not turn off");

  property p_uvp;
    st_r == bps_pkg::ST_RUN && uv_cond && allowed |=> st_r == bps_pkg::ST_HICCUP && uvp_o == 1'b0
      ##1 uvp_o;
  endproperty
  a_uvp: assert property (p_uvp) else $error("undervoltage did not hiccup");

  property p_track_ovp;
    track_cond |=> !power_good_output_o && phase_level_o == '0 && phase_tristate_o == '0;
  endproperty
  a_track_ovp: assert property (p_track_ovp) else $error("tracking ovp not acted");

  property p_blank;
    target_moving |=> !track_ovp_o;
  endproperty
  a_blank: assert property (p_blank) else $error("tracking ovp during target change");

  property p_fixed_hold;
    fixed_ovp_o && enable_s && bias_ok_r |=> fixed_ovp_o;
  endproperty
  a_fixed_hold: assert property (p_fixed_hold) else $error("fixed ovp released");

  property p_prebias_hold;
    prebias_ovp_o && bias_ok_r |=> prebias_ovp_o && phase_level_o == '0;
  endproperty
  a_prebias_hold: assert property (p_prebias_hold) else $error("pre-bias latch released");

endmodule

// >>> bps_cfg.svh
// bps_cfg.svh: offsets, thresholds, reset values and timing counts
// assumes: included by bare name; all voltages are digitized in millivolts
`ifndef BPS_CFG_SVH
`define BPS_CFG_SVH

// clock and timing
`define BPS_CLK_MHZ        100
`define BPS_RST_MIN_NS     1000
// strictly greater than the minimum, so one cycle more than the rounded count
`define BPS_RST_CYC        ((`BPS_RST_MIN_NS * `BPS_CLK_MHZ) / 1000 + 1)
`define BPS_HICCUP_MS      22
`define BPS_HICCUP_CYC     (`BPS_HICCUP_MS * `BPS_CLK_MHZ * 1000)
`define BPS_SLEW_BASE_CYC  16'h0064

// thermal sense, temperature in tenths of a degree
`define BPS_THERMAL_SENSE_INPUT_OFS_MV    16'h0258
`define BPS_THERMAL_SENSE_INPUT_FAULT_MV  16'h09c4
`define BPS_TEMP_MAX_DC    11'h4ff

// bias supply lockout and pre-bias overvoltage
`define BPS_BIAS_OFF_MV    16'h0fd2
`define BPS_BIAS_ON_MV     16'h109a
`define BPS_PREBIAS_OVP_MV 16'h0abe

// input lockout setting and its turn-on / turn-off levels
`define BPS_UVLO_CFG_RST   2'h1
`define BPS_UVLO0_ON_MV    16'h1194
`define BPS_UVLO0_OFF_MV   16'h0dac
`define BPS_UVLO1_ON_MV    16'h1c52
`define BPS_UVLO1_OFF_MV   16'h186a
`define BPS_UVLO2_ON_MV    16'h2328
`define BPS_UVLO2_OFF_MV   16'h1f40
`define BPS_UVLO3_ON_MV    16'h283c
`define BPS_UVLO3_OFF_MV   16'h2454

`endif

// >>> bps_pkg.sv
// bps_pkg.sv: types shared by the protection sequencer files
// assumes: compiled before every other file of the block
package bps_pkg;
  typedef logic [15:0] bps_mv_t;
  typedef enum logic [1:0] {ST_OFF, ST_SOFT, ST_RUN, ST_HICCUP} bps_state_e;
endpackage

// >>> bps_temp_if.sv
// bps_temp_if.sv: thermal-sense reading and its derived values
// assumes: one converter and one consumer on the same clock
`timescale 1ns/10ps
interface bps_temp_if;
  bps_pkg::bps_mv_t sense_mv;
  logic [10:0]      temp_dc;
  logic             stage_fault;
  modport conv (input sense_mv, output temp_dc, output stage_fault);
  modport user (output sense_mv, input temp_dc, input stage_fault);
endinterface

// >>> bps_sync.sv
// bps_sync.sv: two-flop synchroniser for pin levels
// assumes: inputs are slow levels from outside the clock domain
`timescale 1ns/10ps
module bps_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      meta_r <= '0;
      q_o    <= '0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule

// >>> bps_temp_conv.sv
// bps_temp_conv.sv: thermal-sense voltage to temperature, and stage fault
// assumes: sense voltage in millivolts, result in tenths of a degree
`include "bps_cfg.svh"
`timescale 1ns/10ps
module bps_temp_conv (
  bps_temp_if.conv t
);
  logic [15:0] above_ofs;
  logic [19:0] scaled;

  // (v - 0.6) / 0.008 degrees is (mv - 600) * 5 / 4 tenths
  always_comb begin
    above_ofs = (t.sense_mv > `BPS_THERMAL_SENSE_INPUT_OFS_MV) ? t.sense_mv - `BPS_THERMAL_SENSE_INPUT_OFS_MV : 16'h0000;
    scaled    = ({4'h0, above_ofs} * 20'h00005) >> 2;
    if (scaled > {9'h000, `BPS_TEMP_MAX_DC}) begin
      t.temp_dc = `BPS_TEMP_MAX_DC;
    end else begin
      t.temp_dc = scaled[10:0];
    end
    t.stage_fault = (t.sense_mv > `BPS_THERMAL_SENSE_INPUT_FAULT_MV);
  end
endmodule

// >>> bps_stage_model.sv
// bps_stage_model.sv: power stages and load asic beside the sequencer
// assumes: the bench commands die voltage, stage error and reset request
`timescale 1ns/10ps
module bps_stage_model (
  input  wire logic        ref_clk_i,
  input  wire logic [15:0] die_mv_i,
  input  wire logic        stage_err_i,
  input  wire logic        asic_rst_i,
  output logic      [15:0] thermal_sense_mv_o,
  output logic             load_reset_n_o
);
  initial thermal_sense_mv_o = 16'h0320;
  initial load_reset_n_o = 1'b1;
  // a faulted stage pulls the shared sense line to its rail
  always @(posedge ref_clk_i) thermal_sense_mv_o <= stage_err_i ? 16'h0ce4 : die_mv_i;
  // the load drives its pin high again to end the request
  always @(posedge ref_clk_i) load_reset_n_o <= !asic_rst_i;
endmodule

// >>> test_bps_protect_seq.sv
// test_bps_protect_seq.sv: self-checking bench for the protection sequencer
// assumes: design files and bps_stage_model are compiled first
`timescale 1ns/10ps
module test_bps_protect_seq;
  typedef struct {int sel; logic [15:0] m; logic [15:0] v;} bps_note_s;
  localparam logic [15:0] FL_ON = 16'h0001, FL_PB = 16'h0002, FL_FX = 16'h0004;
  localparam logic [15:0] FL_TR = 16'h0008, FL_UV = 16'h0010, FL_RV = 16'h0020;
  localparam logic [15:0] FL_PG = 16'h0040, FL_SK = 16'h0080, FL_SF = 16'h0100;
  logic        ref_clk_i = 1'b0, resetn_i = 1'b0, enable_i = 1'b0;
  logic        input_lockout_wr_i = 1'b0, setpoint_wr_i = 1'b0;
  logic        stage_err = 1'b0, asic_rst = 1'b0;
  logic [15:0] vin_mv_i = 16'h2ee0, bias_mv_i = 16'h1388, vout_mv_i = 16'h03e8;
  logic [15:0] target_mv_i = 16'h03e8, droop_mv_i = 16'h0000, die_mv = 16'h0320;
  logic [15:0] ready_low_margin_mv_i = 16'h0032, track_ovp_ofs_mv_i = 16'h0064;
  logic [15:0] fixed_ovp_mv_i = 16'h05dc;
  logic [1:0]  input_lockout_config_i = 2'h1;
  logic [7:0]  startup_voltage_i = 8'h10, setpoint_i = 8'h00;
  logic [2:0]  slew_sel_i = 3'h0;
  logic [3:0]  pwm_demand_i = 4'h0;
  logic [15:0] thermal_sense_mv_i, mv, e;
  logic        load_reset_n_i;
  logic [3:0]  phase_level_o, phase_tristate_o;
  logic [10:0] stage_temp_output_o;
  logic [7:0]  output_setpoint_o, target_voltage_o;
  logic [1:0]  input_lockout_config_o;
  logic        skip_mode_output_o, power_good_output_o, stage_fault_o, revert_fault_o;
  logic        uvp_o, track_ovp_o, fixed_ovp_o, prebias_ovp_o, converter_on_o;
  logic [15:0] edge_mv [5] = '{16'h0257, 16'h0657, 16'h0658, 16'h09c4, 16'h09c5};
  logic [15:0] on_mv [4] = '{16'h1194, 16'h1c52, 16'h2328, 16'h283c};
  logic [15:0] off_mv [4] = '{16'h0dac, 16'h186a, 16'h1f40, 16'h2454};
  bps_note_s   notes[$];
  bps_note_s   cur;
  int          fail_count = 0, checks_done = 0, c;
  int          seed = 32'hc5fb;

  always #5 ref_clk_i = ~ref_clk_i;
  bps_stage_model stage_m (.ref_clk_i, .die_mv_i(die_mv), .stage_err_i(stage_err),
    .asic_rst_i(asic_rst), .thermal_sense_mv_o(thermal_sense_mv_i),
    .load_reset_n_o(load_reset_n_i));
  bps_protect_seq #(.NPH(4), .HICCUP_CYC(50)) uut (.ref_clk_i, .resetn_i, .enable_i,
    .load_reset_n_i, .vin_mv_i, .bias_mv_i, .vout_mv_i, .target_mv_i, .droop_mv_i,
    .ready_low_margin_mv_i, .track_ovp_ofs_mv_i, .fixed_ovp_mv_i, .thermal_sense_mv_i,
    .input_lockout_wr_i, .input_lockout_config_i, .startup_voltage_i, .setpoint_wr_i,
    .setpoint_i, .slew_sel_i, .pwm_demand_i, .phase_level_o, .phase_tristate_o,
    .skip_mode_output_o, .power_good_output_o, .stage_temp_output_o, .stage_fault_o,
    .output_setpoint_o, .target_voltage_o, .revert_fault_o, .uvp_o, .track_ovp_o,
    .fixed_ovp_o, .prebias_ovp_o, .converter_on_o, .input_lockout_config_o);
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] obs(input int sel);
    case (sel)
      0: return {5'h00, stage_temp_output_o};
      1: return {7'h00, stage_fault_o, skip_mode_output_o, power_good_output_o,
                 revert_fault_o, uvp_o, track_ovp_o, fixed_ovp_o, prebias_ovp_o,
                 converter_on_o};
      2: return {12'h000, phase_level_o};
      3: return {12'h000, phase_tristate_o};
      4: return {8'h00, output_setpoint_o};
      5: return {8'h00, target_voltage_o};
      default: return {14'h0000, input_lockout_config_o};
    endcase
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  // notes are compared at the next falling edge, when outputs have settled
  task automatic want(input int sel, input logic [15:0] m, input logic [15:0] v);
    notes.push_back('{sel, m, v});
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // always lets one edge pass, so no input is driven twice in one step
  task automatic wait_on(input int sel, input logic [15:0] m, input logic [15:0] v,
                         input int lim);
    int i;
    i = 0;
    do begin
      step(1);
      i++;
    end while (i < lim && (obs(sel) & m) !== v);
    want(sel, m, v);
  endtask
  task automatic lvl(input bit b, input logic [15:0] v);
    if (b) bias_mv_i <= v;
    else vin_mv_i <= v;
  endtask
  task automatic hyst(input bit b, input logic [15:0] on, input logic [15:0] off);
    lvl(b, 16'h0000);
    step(4);
    lvl(b, on);
    step(8);
    want(1, FL_ON, 16'h0000);
    lvl(b, on + 16'h0001);
    wait_on(1, FL_ON, FL_ON, 8);
    lvl(b, off);
    step(8);
    want(1, FL_ON, FL_ON);
    lvl(b, off - 16'h0001);
    wait_on(1, FL_ON, 16'h0000, 8);
  endtask
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(negedge ref_clk_i)
    while (notes.size() > 0) begin
      cur = notes.pop_front();
      check(obs(cur.sel) & cur.m, cur.v);
    end
  initial begin
    #400000;
    fail_count++;
    print_verdict();
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    step(3);
    want(3, 16'h000f, 16'h000f);
    want(6, 16'h0003, 16'h0001);
    resetn_i <= 1'b1;
    for (c = 0; c < 29; c++) begin
      mv = (c < 5) ? edge_mv[c] : 16'($unsigned($random(seed)) % 3200);
      die_mv <= mv;
      step(4);
      e = (mv < 16'h0258) ? 16'h0000 : ((mv - 16'h0258) * 16'h000a) / 16'h0008;
      want(0, 16'hffff, (e > 16'h04ff) ? 16'h04ff : e);
      want(1, FL_SF, (mv > 16'h09c4) ? FL_SF : 16'h0000);
    end
    $display("test temperature done");
    enable_i <= 1'b1;
    for (c = 0; c < 4; c++) begin
      input_lockout_config_i <= 2'(c);
      input_lockout_wr_i <= 1'b1;
      step(1);
      input_lockout_wr_i <= 1'b0;
      want(6, 16'h0003, 16'(c));
      hyst(1'b0, on_mv[c], off_mv[c]);
    end
    vin_mv_i <= 16'h2ee0;
    hyst(1'b1, 16'h109a, 16'h0fd2);
    enable_i <= 1'b0;
    wait_on(1, FL_ON, 16'h0000, 8);
    $display("test lockout done");
    bias_mv_i <= 16'h1388;
    enable_i <= 1'b1;
    wait_on(1, FL_ON, FL_ON, 8);
    step(2);
    want(1, FL_SK, 16'h0000);
    wait_on(1, FL_PG, FL_PG, 4000);
    want(1, FL_SK, FL_SK);
    for (c = 0; c < 8; c++) begin
      pwm_demand_i <= 4'($random(seed));
      step(3);
      want(2, 16'h000f, {12'h000, pwm_demand_i});
    end
    stage_err <= 1'b1;
    step(4);
    want(3, 16'h000f, 16'h000f);
    stage_err <= 1'b0;
    wait_on(3, 16'h000f, 16'h0000, 8);
    $display("test startup done");
    vout_mv_i <= 16'h044d;
    step(4);
    want(1, FL_TR | FL_PG, FL_TR);
    want(2, 16'h000f, 16'h0000);
    vout_mv_i <= 16'h03e8;
    wait_on(1, FL_PG, FL_PG, 8);
    setpoint_i <= 8'h20;
    setpoint_wr_i <= 1'b1;
    step(1);
    setpoint_wr_i <= 1'b0;
    vout_mv_i <= 16'h044d;
    step(10);
    want(1, FL_TR, 16'h0000);
    vout_mv_i <= 16'h05dd;
    step(4);
    want(1, FL_FX | FL_PG, FL_FX);
    want(2, 16'h000f, 16'h0000);
    vout_mv_i <= 16'h03e8;
    step(8);
    want(1, FL_FX, FL_FX);
    enable_i <= 1'b0;
    wait_on(1, FL_FX, 16'h0000, 8);
    vout_mv_i <= 16'h0abf;
    step(6);
    want(1, FL_PB, FL_PB);
    want(3, 16'h000f, 16'h0000);
    vout_mv_i <= 16'h03e8;
    enable_i <= 1'b1;
    step(20);
    want(1, FL_PB, FL_PB);
    bias_mv_i <= 16'h0fd1;
    step(6);
    bias_mv_i <= 16'h1388;
    wait_on(1, FL_PB, 16'h0000, 8);
    $display("test overvoltage done");
    wait_on(1, FL_PG, FL_PG, 4000);
    slew_sel_i <= 3'h1;
    startup_voltage_i <= 8'h12;
    setpoint_i <= 8'h14;
    setpoint_wr_i <= 1'b1;
    step(1);
    setpoint_wr_i <= 1'b0;
    wait_on(5, 16'h00ff, 16'h0014, 1000);
    asic_rst <= 1'b1;
    step(90);
    want(1, FL_RV, 16'h0000);
    step(20);
    want(1, FL_RV, FL_RV);
    want(4, 16'h00ff, 16'h0012);
    wait_on(5, 16'h00ff, 16'h0012, 600);
    asic_rst <= 1'b0;
    wait_on(1, FL_RV, 16'h0000, 8);
    $display("test revert done");
    startup_voltage_i <= 8'h11;
    vout_mv_i <= 16'h03b5;
    step(3);
    want(1, FL_UV | FL_PG, FL_UV);
    want(3, 16'h000f, 16'h000f);
    vout_mv_i <= 16'h03e8;
    step(40);
    want(1, FL_UV, FL_UV);
    step(15);
    want(1, FL_UV, 16'h0000);
    want(4, 16'h00ff, 16'h0011);
    $display("test hiccup done");
    step(2);
    print_verdict();
  end
endmodule
